// ===== src/mpo_pkg.sv
package mpo_pkg;

   localparam int QW = 16;          // monitored quantity width
   localparam int FS_W = 13;        // full-scale rate field width
   localparam int AV_W = 8;         // average-voltage field width
   localparam int ACC_W = 32;       // phase accumulator width

   // Register indices.
   localparam logic [3:0] REG_TERM_SEL  = 4'h0;
   localparam logic [3:0] REG_AMON_ITEM = 4'h1;
   localparam logic [3:0] REG_PFS_RATE  = 4'h2;
   localparam logic [3:0] REG_PAVG      = 4'h3;
   localparam logic [3:0] REG_PMON_ITEM = 4'h4;
   localparam logic [3:0] REG_SCALED    = 4'h5;
   localparam logic [3:0] REG_STATUS    = 4'h6;
   localparam logic [3:0] REG_AVOLT_ADJ = 4'h7;

   // Reset values.
   localparam logic [3:0]  RST_ITEM     = 4'h0;
   localparam logic [12:0] RST_PFS_RATE = 13'h05A0;
   localparam logic [7:0]  RST_PAVG     = 8'h00;
   localparam logic [7:0]  RST_AVOLT    = 8'h64;

   // Limits of the settings, and the fixed pulse rate used when averaging.
   localparam logic [3:0]  ITEM_MAX     = 4'h8;
   localparam logic [12:0] PFS_MIN      = 13'h012C;
   localparam logic [12:0] PFS_MAX      = 13'h1770;
   localparam logic [7:0]  PAVG_MAX     = 8'hC8;
   localparam logic [12:0] FIXED_RATE   = 13'h0A6E;

   // Clock figures.
   localparam int CLK_HZ = 40000000;

   typedef enum logic [3:0] {
      MPO_FREQ_PRE  = 4'h0,
      MPO_FREQ_POST = 4'h1,
      MPO_CURRENT   = 4'h2,
      MPO_VOLTAGE   = 4'h3,
      MPO_TORQUE    = 4'h4,
      MPO_LOAD      = 4'h5,
      MPO_IN_POWER  = 4'h6,
      MPO_PID_FB    = 4'h7,
      MPO_DC_LINK   = 4'h8
   } mpo_item_t;

   // Raw quantities from the drive, each in its own unit.
   typedef struct packed {
      logic [QW-1:0] freq_pre;
      logic [QW-1:0] freq_post;
      logic [QW-1:0] current;
      logic [QW-1:0] voltage;
      logic [QW-1:0] torque;
      logic [QW-1:0] load;
      logic [QW-1:0] in_power;
      logic [QW-1:0] pid_fb;
      logic [QW-1:0] dc_link;
   } mpo_meas_t;

   // References for the same quantities; full scale is twice the rated values, set by class_400v for voltage and DC link.
   typedef struct packed {
      logic [QW-1:0] max_freq;
      logic [QW-1:0] rated_current;
      logic [QW-1:0] rated_torque;
      logic [QW-1:0] rated_load;
      logic [QW-1:0] rated_power;
      logic [QW-1:0] pid_full;
      logic          class_400v;
   } mpo_ref_t;

endpackage

// ===== src/mpo_monitor_pulse_output.sv
`timescale 1ns/10ps
module mpo_monitor_pulse_output #(
   parameter int ACC_W = mpo_pkg::ACC_W
) (
   input  wire logic                    core_clk,
   input  wire logic                    arst_n,
   input  wire logic                    clk_en,
   input  wire logic [3:0]              reg_addr,
   input  wire logic [15:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [15:0]             reg_rdata,
   input  wire mpo_pkg::mpo_meas_t      meas,
   input  wire mpo_pkg::mpo_ref_t       refs,
   output logic                         meter_pulse,
   output logic                         meter_pulse_en,
   output logic      [15:0]             meter_level,
   output logic                         meter_level_en
);

   localparam logic [15:0] PCT100 = 16'h2710;
   localparam logic [15:0] V250  = 16'h00FA;
   localparam logic [15:0] V500  = 16'h01F4;
   localparam logic [15:0] V1000 = 16'h03E8;
   localparam logic [63:0] CLK_HZ64 = 64'(mpo_pkg::CLK_HZ);

   // Scaled value is in hundredths of a percent, clipped at 200 percent.
   function automatic logic [15:0] pct(input logic [15:0] val,
                                       input logic [15:0] fs);
      logic [31:0] q;
      q = 32'h0;
      if (fs != 16'h0) begin
         q = ({16'h0, val} * 32'(PCT100)) / {16'h0, fs};
      end
      if (q > 32'h4E20) begin
         q = 32'h4E20;
      end
      return q[15:0];
   endfunction

   function automatic logic [15:0] pick(input logic [3:0] item,
                                        input mpo_pkg::mpo_meas_t m,
                                        input mpo_pkg::mpo_ref_t r);
      logic [15:0] res;
      res = 16'h0;
      case (item)
         mpo_pkg::MPO_FREQ_PRE:  res = pct(m.freq_pre, r.max_freq);
         mpo_pkg::MPO_FREQ_POST: res = pct(m.freq_post, r.max_freq);
         mpo_pkg::MPO_CURRENT:
            res = pct(m.current, {r.rated_current[14:0], 1'b0});
         mpo_pkg::MPO_VOLTAGE:
            res = pct(m.voltage, r.class_400v ? V500 : V250);
         mpo_pkg::MPO_TORQUE:
            res = pct(m.torque, {r.rated_torque[14:0], 1'b0});
         mpo_pkg::MPO_LOAD:
            res = pct(m.load, {r.rated_load[14:0], 1'b0});
         mpo_pkg::MPO_IN_POWER:
            res = pct(m.in_power, {r.rated_power[14:0], 1'b0});
         mpo_pkg::MPO_PID_FB:    res = pct(m.pid_fb, r.pid_full);
         mpo_pkg::MPO_DC_LINK:
            res = pct(m.dc_link, r.class_400v ? V1000 : V500);
         default:                res = 16'h0;
      endcase
      return res;
   endfunction

   logic        term_sel_q,  term_sel_d;
   logic [3:0]  amon_item_q, amon_item_d;
   logic [3:0]  pmon_item_q, pmon_item_d;
   logic [12:0] pfs_rate_q,  pfs_rate_d;
   logic [7:0]  pavg_q,      pavg_d;
   logic [7:0]  avolt_q,     avolt_d;
   logic [15:0] rdata_q,     rdata_d;
   logic [15:0] ascaled_q,   ascaled_d;
   logic [15:0] pscaled_q,   pscaled_d;
   logic [ACC_W-1:0] acc_q,  acc_d;
   logic [ACC_W-1:0] inc_q,  inc_d;
   logic [15:0] duty_q,      duty_d;
   logic        pulse_q,     pulse_d;
   logic        pen_q,       pen_d;
   logic [15:0] level_q,     level_d;
   logic        len_q,       len_d;
   logic [ACC_W:0] acc_sum;
   logic [63:0] inc_full;
   logic [63:0] lvl_full;

   always_comb begin
      term_sel_d  = term_sel_q;
      amon_item_d = amon_item_q;
      pmon_item_d = pmon_item_q;
      pfs_rate_d  = pfs_rate_q;
      pavg_d      = pavg_q;
      avolt_d     = avolt_q;
      rdata_d     = 16'h0;
      if (reg_wr) begin
         if (reg_addr == mpo_pkg::REG_TERM_SEL) begin
            term_sel_d = reg_wdata[0];
         end else if (reg_addr == mpo_pkg::REG_AMON_ITEM) begin
            if (reg_wdata[3:0] <= mpo_pkg::ITEM_MAX) begin
               amon_item_d = reg_wdata[3:0];
            end
         end else if (reg_addr == mpo_pkg::REG_PFS_RATE) begin
            if (reg_wdata[12:0] >= mpo_pkg::PFS_MIN
                && reg_wdata[12:0] <= mpo_pkg::PFS_MAX
                && reg_wdata[15:13] == 3'h0) begin
               pfs_rate_d = reg_wdata[12:0];
            end
         end else if (reg_addr == mpo_pkg::REG_PAVG) begin
            if (reg_wdata[7:0] <= mpo_pkg::PAVG_MAX
                && reg_wdata[15:8] == 8'h0) begin
               pavg_d = reg_wdata[7:0];
            end
         end else if (reg_addr == mpo_pkg::REG_PMON_ITEM) begin
            if (reg_wdata[3:0] <= mpo_pkg::ITEM_MAX) begin
               pmon_item_d = reg_wdata[3:0];
            end
         end else if (reg_addr == mpo_pkg::REG_AVOLT_ADJ) begin
            if (reg_wdata[7:0] <= mpo_pkg::PAVG_MAX
                && reg_wdata[15:8] == 8'h0) begin
               avolt_d = reg_wdata[7:0];
            end
         end
      end
      if (reg_rd) begin
         if (reg_addr == mpo_pkg::REG_TERM_SEL) begin
            rdata_d = {15'h0, term_sel_q};
         end else if (reg_addr == mpo_pkg::REG_AMON_ITEM) begin
            rdata_d = {12'h0, amon_item_q};
         end else if (reg_addr == mpo_pkg::REG_PFS_RATE) begin
            rdata_d = {3'h0, pfs_rate_q};
         end else if (reg_addr == mpo_pkg::REG_PAVG) begin
            rdata_d = {8'h0, pavg_q};
         end else if (reg_addr == mpo_pkg::REG_PMON_ITEM) begin
            rdata_d = {12'h0, pmon_item_q};
         end else if (reg_addr == mpo_pkg::REG_SCALED) begin
            rdata_d = term_sel_q ? pscaled_q : ascaled_q;
         end else if (reg_addr == mpo_pkg::REG_STATUS) begin
            rdata_d = {13'h0, pen_q, len_q, pulse_q};
         end else if (reg_addr == mpo_pkg::REG_AVOLT_ADJ) begin
            rdata_d = {8'h0, avolt_q};
         end else begin
            rdata_d = 16'h0;
         end
      end
   end

   always_comb begin
      ascaled_d = pick(amon_item_q, meas, refs);
      pscaled_d = pick(pmon_item_q, meas, refs);
      if (pavg_q == 8'h0) begin
         // proportional rate
         // Toggling halves the wrap rate, so this increment is doubled.
         inc_full = (64'(pscaled_q) * 64'(pfs_rate_q)
                     * (64'h1 << (ACC_W + 1))) / (CLK_HZ64 * 64'(PCT100));
      end else begin
         inc_full = (64'(mpo_pkg::FIXED_RATE) * (64'h1 << ACC_W))
                    / CLK_HZ64;
      end
      inc_d = inc_full[ACC_W-1:0];
      // duty equals quantity times setting, in 1/65536 of period
      duty_d = 16'h0;
      if (pavg_q != 8'h0) begin
         lvl_full = (64'(pscaled_q) * 64'(pavg_q) * 64'd65536)
                    / (64'(PCT100) * 64'd100);
         duty_d = (lvl_full > 64'h0000FFFF) ? 16'hFFFF : lvl_full[15:0];
      end else begin
         lvl_full = 64'h0;
      end
      acc_sum = {1'b0, acc_q} + {1'b0, inc_q};
      acc_d = acc_sum[ACC_W-1:0];
      if (pavg_q == 8'h0) begin
         // pulse toggles on each wrap, two wraps per pulse period.
         pulse_d = acc_sum[ACC_W] ? ~pulse_q : pulse_q;
      end else begin
         // high while phase is below the duty
         pulse_d = acc_q[ACC_W-1 -: 16] < duty_q;
      end
      // analogue level when select is zero
      pen_d   = term_sel_q;
      len_d   = ~term_sel_q;
      level_d = 16'(({16'h0, ascaled_q} * {24'h0, avolt_q}) / 32'd100);
      if (!term_sel_q) begin
         pulse_d = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         term_sel_q  <= 1'b0;
         amon_item_q <= mpo_pkg::RST_ITEM;
         pmon_item_q <= mpo_pkg::RST_ITEM;
         pfs_rate_q  <= mpo_pkg::RST_PFS_RATE;
         pavg_q      <= mpo_pkg::RST_PAVG;
         avolt_q     <= mpo_pkg::RST_AVOLT;
         rdata_q     <= 16'h0;
         ascaled_q   <= 16'h0;
         pscaled_q   <= 16'h0;
         acc_q       <= '0;
         inc_q       <= '0;
         duty_q      <= 16'h0;
         pulse_q     <= 1'b0;
         pen_q       <= 1'b0;
         level_q     <= 16'h0;
         len_q       <= 1'b0;
      end else if (clk_en) begin
         term_sel_q  <= term_sel_d;
         amon_item_q <= amon_item_d;
         pmon_item_q <= pmon_item_d;
         pfs_rate_q  <= pfs_rate_d;
         pavg_q      <= pavg_d;
         avolt_q     <= avolt_d;
         rdata_q     <= rdata_d;
         ascaled_q   <= ascaled_d;
         pscaled_q   <= pscaled_d;
         acc_q       <= acc_d;
         inc_q       <= inc_d;
         duty_q      <= duty_d;
         pulse_q     <= pulse_d;
         pen_q       <= pen_d;
         level_q     <= level_d;
         len_q       <= len_d;
      end
   end

   assign reg_rdata      = rdata_q;
   assign meter_pulse    = pulse_q;
   assign meter_pulse_en = pen_q;
   assign meter_level    = level_q;
   assign meter_level_en = len_q;

endmodule

// ===== testbench/mpo_chk_monitor.sv
`timescale 1ns/10ps
module mpo_chk_monitor (
   input wire logic        core_clk,
   input wire logic        arst_n,
   input wire logic        clk_en,
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        meter_pulse,
   input wire logic        meter_pulse_en,
   input wire logic        meter_level_en
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   logic wsel;
   logic rsel;
   assign wsel = clk_en && reg_wr && reg_addr == 4'h0;
   assign rsel = clk_en && reg_rd;
   a_pen_sel: assert property (wsel && reg_wdata == 16'h0001
      |-> ##[1:2] meter_pulse_en && !meter_level_en) else $error("no pulse");
   a_len_sel: assert property (wsel && reg_wdata == 16'h0000
      |-> ##[1:2] meter_level_en && !meter_pulse_en) else $error("no level");
   a_en_excl: assert property (!(meter_pulse_en && meter_level_en))
      else $error("both modes");
   a_amon_range: assert property (rsel && reg_addr == 4'h1
      |=> reg_rdata <= 16'h0008) else $error("item out of range");
   a_pmon_range: assert property (rsel && reg_addr == 4'h4
      |=> reg_rdata <= 16'h0008) else $error("item out of range");
   a_rate_range: assert property (rsel && reg_addr == 4'h2
      |=> reg_rdata inside {[300:6000]}) else $error("rate out of range");
   a_avg_range: assert property (rsel && reg_addr == 4'h3
      |=> reg_rdata <= 16'h00C8) else $error("average out of range");
   a_scaled_clip: assert property (rsel && reg_addr == 4'h5
      |=> reg_rdata <= 16'h4E20) else $error("scaled above clip");
   c_pulse: cover property ($rose(meter_pulse) && meter_pulse_en);
   c_pulse_sel: cover property (wsel && reg_wdata == 16'h0001);
   c_scaled_rd: cover property (rsel && reg_addr == 4'h5);
endmodule
bind mpo_monitor_pulse_output mpo_chk_monitor u_mpo_chk_monitor (
   .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meter_pulse(meter_pulse),
   .meter_pulse_en(meter_pulse_en), .meter_level_en(meter_level_en));

// ===== testbench/mpo_meter_model.sv
`timescale 1ns/10ps
module mpo_meter_model (
   input  wire logic core_clk,
   input  wire logic meter_pulse,
   input  wire logic meter_pulse_en,
   input  wire logic run,
   output int        edges,
   output int        high
);
   logic last = 1'b0;
   logic run_q = 1'b0;
   // pulse jumper: counts only while the terminal is in pulse mode.
   always @(posedge core_clk) begin
      last <= meter_pulse;
      run_q <= run;
      if (run && !run_q) begin
         edges <= 0;
         high <= 0;
      end else if (run && meter_pulse_en) begin
         edges <= edges + int'(meter_pulse === 1'b1 && last === 1'b0);
         high <= high + int'(meter_pulse === 1'b1);
      end
   end
endmodule

// ===== testbench/monitor_pulse_output_test.sv
`timescale 1ns/10ps
module monitor_pulse_output_test;
   logic               core_clk = 1'b0;
   logic               arst_n = 1'b0;
   logic [3:0]         reg_addr = 4'h0;
   logic [15:0]        reg_wdata = 16'h0000;
   logic               reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0, run = 1'b0;
   logic               clk_en = 1'b1;
   logic [15:0]        reg_rdata, meter_level;
   logic               meter_pulse, meter_pulse_en, meter_level_en;
   mpo_pkg::mpo_meas_t meas;
   mpo_pkg::mpo_ref_t  refs;
   logic [15:0]        exp_q[$];
   logic [15:0]        tbl[9] = '{16'h1388, 16'h2710, 16'h07D0,
                                  16'h1388, 16'h1388, 16'h03E8,
                                  16'h2710, 16'h0BB8, 16'h1388};
   int                 err_total = 0, n_tests = 0, seed = 34362;
   int                 edges, high, i, c;

   always #12.5 core_clk = ~core_clk;

   mpo_monitor_pulse_output u_mpo_monitor_pulse_output (
      .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas(meas), .refs(refs),
      .meter_pulse(meter_pulse), .meter_pulse_en(meter_pulse_en),
      .meter_level(meter_level), .meter_level_en(meter_level_en));
   mpo_meter_model u_mpo_meter_model (
      .core_clk(core_clk), .meter_pulse(meter_pulse),
      .meter_pulse_en(meter_pulse_en), .run(run), .edges(edges), .high(high));

   task automatic chk(input string nm, input logic [31:0] lo, hi, g);
      n_tests++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         err_total++;
         $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic bus(input logic w, r, input logic [3:0] a,
                      input logic [15:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      bus(1'b0, 1'b1, a, 16'h0000);
   endtask

   // Read data stand only in the cycle after the strobe.
   always @(posedge core_clk) rd_q <= reg_rd;
   always @(negedge core_clk) begin
      if (rd_q) begin
         chk("reg_rdata", exp_q[0], exp_q[0], reg_rdata);
         void'(exp_q.pop_front());
      end
   end

   // Whole-window count; edge and high-time bounds allow one partial period.
   task automatic win(input int e_lo, e_hi, h_lo, h_hi);
      bus(1'b0, 1'b0, 4'h0, 16'h0000);
      repeat (20) @(posedge core_clk);
      run <= 1'b1;
      repeat (40000) @(posedge core_clk);
      run <= 1'b0;
      @(posedge core_clk);
      chk("pulse_edges", e_lo, e_hi, edges);
      chk("pulse_high", h_lo, h_hi, high);
   endtask

   initial begin
      #(95000 * 25);
      err_total++;
      end_of_test;
   end

   initial begin
      meas = {16'h01F4, 16'h03E8, 16'h0190, 16'h007D, 16'h03E8,
              16'h00C8, 16'h07D0, 16'h012C, 16'h00FA};
      refs = {{6{16'h03E8}}, 1'b0};
      repeat (6) @(posedge core_clk);
      arst_n <= 1'b1;
      rd(4'h0, 16'h0000);
      rd(4'h2, 16'h05A0);
      rd(4'h3, 16'h0000);
      rd(4'h7, 16'h0064);
      rd(4'h8 | 4'($random(seed) & 7), 16'h0000);
      bus(1'b1, 1'b0, 4'h2, 16'h012B);
      bus(1'b1, 1'b0, 4'h2, 16'h1771);
      bus(1'b1, 1'b0, 4'h4, 16'h0009);
      bus(1'b1, 1'b0, 4'h3, 16'h00C9);
      // A write while the enable is low must leave the setting alone.
      clk_en <= 1'b0;
      bus(1'b1, 1'b0, 4'h3, 16'h0032);
      clk_en <= 1'b1;
      rd(4'h2, 16'h05A0);
      rd(4'h4, 16'h0000);
      rd(4'h3, 16'h0000);
      c = 300 + ($random(seed) & 16'h0FFF);
      bus(1'b1, 1'b0, 4'h2, 16'(c));
      rd(4'h2, 16'(c));
      bus(1'b1, 1'b0, 4'h2, 16'h012C);
      rd(4'h2, 16'h012C);
      for (c = 0; c < 2; c++) begin
         refs.class_400v <= c[0];
         bus(1'b1, 1'b0, 4'h0, 16'(1 - c));
         for (i = 0; i < 9; i++) begin
            bus(1'b1, 1'b0, c ? 4'h1 : 4'h4, 16'(i));
            bus(1'b0, 1'b0, 4'h0, 16'h0000);
            bus(1'b0, 1'b0, 4'h0, 16'h0000);
            rd(4'h5, tbl[i] >> (c == 1 && (i == 3 || i == 8)));
         end
      end
      chk("meter_level", 16'h09C4, 16'h09C4, meter_level);
      bus(1'b1, 1'b0, 4'h0, 16'h0001);
      bus(1'b1, 1'b0, 4'h4, 16'h0001);
      bus(1'b1, 1'b0, 4'h2, 16'h1770);
      win(5, 7, 16000, 24000);
      bus(1'b1, 1'b0, 4'h3, 16'h0019);
      win(2, 3, 6000, 14000);
      end_of_test;
   end
endmodule
